// ### mss_pkg.sv
/*
 * Package for the mode select / soft reset control register: register
 * offset, field layout, reset value and timing constants.
 * Assumes a 100 MHz logic clock.
 */
`default_nettype none

package mss_pkg;

    localparam logic [7:0] MSS_CTL3_OFFSET = 8'h0C;

    // field positions
    localparam int MSS_MODE_HI_BIT = 4;
    localparam int MSS_MODE_LO_BIT = 3;
    localparam int MSS_SOFT_RESET_TRIGGER_BIT = 2;
    localparam int MSS_TIMER_LSB = 0;

    localparam logic [7:0] MSS_CTL3_RESET = 8'h01;
    localparam logic [1:0] MSS_TIMER_RESET = 2'h1;

    // timing
    localparam int MSS_CLK_PERIOD_NS = 10;
    localparam int MSS_SECOND_NS = 1000000000;
    localparam int MSS_SECOND_CYCLES = MSS_SECOND_NS / MSS_CLK_PERIOD_NS;
    localparam int MSS_TIMER_STEP_S = 4;
    localparam int MSS_RAIL_OFF_US = 1000;
    localparam int MSS_RAIL_OFF_CYCLES = (MSS_RAIL_OFF_US * 1000 + MSS_CLK_PERIOD_NS - 1)
        / MSS_CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        MSS_MODE0 = 2'b00,
        MSS_MODE1 = 2'b01,
        MSS_MODE2 = 2'b10,
        MSS_MODE3 = 2'b11
    } mss_mode_t;

    typedef struct packed {
        logic [2:0] reserved_bits;
        logic mode_select_high_bit;
        logic mode_select_low_bit;
        logic soft_reset_trigger;
        logic [1:0] on_key_long_press_timer;
    } mss_ctl3_t;

    typedef enum logic [0:0] {
        MSS_RAILS_ON = 1'b0,
        MSS_RAILS_OFF = 1'b1
    } mss_rail_state_t;

endpackage : mss_pkg

`default_nettype wire

// ### mss_long_press.sv
/*
 * ON key long-press detector: flags a press held for 4, 8, 12 or 16 s.
 * Assumes the key level is already debounced and synchronous to clk.
 */
`timescale 1ns/100ps
`default_nettype none

module mss_long_press #(
    parameter int SECOND_CYCLES = mss_pkg::MSS_SECOND_CYCLES
) (
    input wire logic clk, // logic clock
    input wire logic rst, // sync reset, active high
    input wire logic on_key_pressed, // key held, active high
    input wire logic [1:0] on_key_long_press_timer, // duration code
    output logic long_press // one-cycle pulse at threshold
);
    import mss_pkg::*;

    initial begin
        if (SECOND_CYCLES < 1 || 64'(SECOND_CYCLES) * 16 >= 64'h80000000)
            $error("mss_long_press: SECOND_CYCLES out of range");
    end

    logic [31:0] count_q, count_d;
    logic fired_q, fired_d;
    logic long_press_q, long_press_d;
    logic [31:0] limit;

    // 00:4s 01:8s 10:12s 11:16s
    always_comb begin
        limit = 32'(({30'h0, on_key_long_press_timer} + 32'h1) * 32'(MSS_TIMER_STEP_S)
            * 32'(SECOND_CYCLES));
        count_d = count_q;
        fired_d = fired_q;
        long_press_d = 1'b0;
        if (!on_key_pressed) begin
            count_d = 32'h0;
            fired_d = 1'b0;
        end else if (!fired_q) begin
            count_d = count_q + 32'h1;
            if (count_d >= limit) begin
                fired_d = 1'b1;
                long_press_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            count_q <= 32'h0;
            fired_q <= 1'b0;
            long_press_q <= 1'b0;
        end else begin
            count_q <= count_d;
            fired_q <= fired_d;
            long_press_q <= long_press_d;
        end
    end

    assign long_press = long_press_q;

endmodule : mss_long_press

`default_nettype wire

// ### mss_mode_select_soft_reset_reg.sv
/*
 * Top level control register three: chip mode selection, self-clearing
 * software reset with regulator cycling, and ON key long-press timer.
 * Assumes the device's serial target engine delivers register accesses as
 * one-cycle strobes with an 8-bit address, synchronous to clk.
 */
// Function
// - With the pin source enable low, the chip mode comes from the two register mode bits.
// - The mode bits, high bit first, decode 00/01/10/11 as mode 0/1/2/3.
// - With the pin source enable high, the chip mode comes from the two mode select pins.
// - Writing one to the soft reset bit returns every other register bit to its default.
// - A soft reset also cycles the regulator outputs off and back on.
// - The soft reset bit clears itself, so it always reads back zero.
// - The long-press timer field picks 4, 8, 12 or 16 s and resets to code 01.
// - Other bits are read/write; the upper three are reserved and default to zero.
`timescale 1ns/100ps
`default_nettype none

module mss_mode_select_soft_reset_reg #(
    parameter int RAIL_OFF_CYCLES = mss_pkg::MSS_RAIL_OFF_CYCLES,
    parameter int SECOND_CYCLES = mss_pkg::MSS_SECOND_CYCLES
) (
    input wire logic clk, // logic clock, 100 MHz
    input wire logic rst, // sync reset, active high
    input wire logic reg_wr, // write strobe, one cycle
    input wire logic reg_rd, // read strobe, one cycle
    input wire logic [7:0] reg_addr, // register address
    input wire logic [7:0] reg_wdata, // write data
    output logic [7:0] reg_rdata, // read data, valid cycle after reg_rd
    input wire logic pin_mode_source_enable, // mode from pins when high
    input wire logic [1:0] mode_select_pin, // external mode pins
    output mss_pkg::mss_mode_t chip_mode, // selected operating mode
    output logic soft_reset_pulse, // one cycle: others to defaults
    output logic rails_enable, // regulator outputs enabled
    input wire logic on_key_pressed, // ON key held, active high
    output logic long_press // long-press detected pulse
);
    import mss_pkg::*;

    initial begin
        if (RAIL_OFF_CYCLES < 1 || RAIL_OFF_CYCLES >= 32'h7FFFFFFF)
            $error("mss: RAIL_OFF_CYCLES out of range");
    end

    mss_ctl3_t ctl_q, ctl_d;
    logic [7:0] rdata_q, rdata_d;
    mss_mode_t mode_q, mode_d;
    logic srst_q, srst_d;
    mss_rail_state_t rail_q, rail_d;
    logic [31:0] rail_cnt_q, rail_cnt_d;
    logic hit;
    logic do_srst;

    assign hit = (reg_addr == MSS_CTL3_OFFSET);
    assign do_srst = reg_wr && hit && reg_wdata[MSS_SOFT_RESET_TRIGGER_BIT];

    // register file
    always_comb begin
        ctl_d = ctl_q;
        rdata_d = rdata_q;
        srst_d = 1'b0;
        if (do_srst) begin
            ctl_d = mss_ctl3_t'(MSS_CTL3_RESET);
            srst_d = 1'b1;
        end else if (reg_wr && hit) begin
            ctl_d = mss_ctl3_t'(reg_wdata);
        end
        ctl_d.soft_reset_trigger = 1'b0;
        if (reg_rd) begin
            rdata_d = hit ? 8'(ctl_q) : 8'h00;
        end
    end

    // mode source select
    always_comb begin
        if (pin_mode_source_enable) begin
            mode_d = mss_mode_t'(mode_select_pin);
        end else begin
            mode_d = mss_mode_t'({ctl_q.mode_select_high_bit,
                ctl_q.mode_select_low_bit});
        end
    end

    // regulator cycling
    always_comb begin
        rail_d = rail_q;
        rail_cnt_d = rail_cnt_q;
        case (rail_q)
            MSS_RAILS_ON: begin
                if (do_srst) begin
                    rail_d = MSS_RAILS_OFF;
                    rail_cnt_d = 32'h0;
                end
            end
            MSS_RAILS_OFF: begin
                rail_cnt_d = rail_cnt_q + 32'h1;
                if (do_srst) begin
                    rail_cnt_d = 32'h0;
                end else if (rail_cnt_d >= 32'(RAIL_OFF_CYCLES)) begin
                    rail_d = MSS_RAILS_ON;
                end
            end
            default: begin
                rail_d = MSS_RAILS_ON;
                rail_cnt_d = 32'h0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctl_q <= mss_ctl3_t'(MSS_CTL3_RESET);
            rdata_q <= 8'h00;
            mode_q <= MSS_MODE0;
            srst_q <= 1'b0;
            rail_q <= MSS_RAILS_ON;
            rail_cnt_q <= 32'h0;
        end else begin
            ctl_q <= ctl_d;
            rdata_q <= rdata_d;
            mode_q <= mode_d;
            srst_q <= srst_d;
            rail_q <= rail_d;
            rail_cnt_q <= rail_cnt_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign chip_mode = mode_q;
    assign soft_reset_pulse = srst_q;
    assign rails_enable = (rail_q == MSS_RAILS_ON);

    mss_long_press #(
        .SECOND_CYCLES(SECOND_CYCLES)
    ) u_long_press (
        .clk(clk),
        .rst(rst),
        .on_key_pressed(on_key_pressed),
        .on_key_long_press_timer(ctl_q.on_key_long_press_timer),
        .long_press(long_press)
    );

endmodule : mss_mode_select_soft_reset_reg

`default_nettype wire

// ### mss_host.sv
/* host model: single-byte register writes and reads.
   drives 1 ns after the rising clk edge. */
`timescale 1ns/100ps
`default_nettype none
module mss_host (
    input wire logic clk, // clock
    output logic reg_wr, // write
    output logic reg_rd, // read
    output logic [7:0] reg_addr, // address
    output logic [7:0] reg_wdata, // data out
    input wire logic [7:0] reg_rdata // data in
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    task automatic acc(input logic w, input logic [7:0] a, d, output logic [7:0] q);
        @(posedge clk);
        #1;
        reg_wr = w;
        reg_rd = !w;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
        q = reg_rdata;
    endtask : acc
endmodule : mss_host
`default_nettype wire

// ### mss_props.sv
/* checker for the control register top.
   bound to the top; one clock, sync reset. */
`timescale 1ns/100ps
`default_nettype none
module mss_props #(parameter int RAIL_OFF_CYCLES = 5) (
    input wire logic clk, // in
    input wire logic rst, // in
    input wire logic reg_wr, // in
    input wire logic reg_rd, // in
    input wire logic [7:0] reg_addr, // in
    input wire logic [7:0] reg_wdata, // in
    input wire logic [7:0] reg_rdata, // in
    input wire logic pin_mode_source_enable, // in
    input wire logic [1:0] mode_select_pin, // in
    input wire mss_pkg::mss_mode_t chip_mode, // in
    input wire logic soft_reset_pulse, // in
    input wire logic rails_enable // in
);
    import mss_pkg::*;
    logic hit;
    assign hit = reg_addr == MSS_CTL3_OFFSET;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_pin; pin_mode_source_enable |=> chip_mode == $past(mode_select_pin); endproperty
    a_pin: assert property (p_pin) else $error("mode not from pins");
    // register source: field lands one edge after the write, mode one edge later
    property p_reg; (!pin_mode_source_enable && !reg_wr)[*4] |-> $stable(chip_mode); endproperty
    a_reg: assert property (p_reg) else $error("mode moved");
    property p_swr;
        reg_wr && hit && reg_wdata[MSS_SOFT_RESET_TRIGGER_BIT] |=> soft_reset_pulse && !rails_enable;
    endproperty
    a_swr: assert property (p_swr) else $error("no reset");
    property p_cause;
        soft_reset_pulse |-> $past(reg_wr && hit && reg_wdata[MSS_SOFT_RESET_TRIGGER_BIT]);
    endproperty
    a_cause: assert property (p_cause) else $error("stray reset");
    property p_back; $rose(rails_enable) |-> $past(soft_reset_pulse, RAIL_OFF_CYCLES); endproperty
    a_back: assert property (p_back) else $error("off time");
    property p_fell; $fell(rails_enable) |-> soft_reset_pulse; endproperty
    a_fell: assert property (p_fell) else $error("rails dropped");
    property p_clr; reg_rd && hit |=> !reg_rdata[MSS_SOFT_RESET_TRIGGER_BIT]; endproperty
    a_clr: assert property (p_clr) else $error("reset bit read one");
    property p_unm; reg_rd && !hit |=> reg_rdata == 8'h00; endproperty
    a_unm: assert property (p_unm) else $error("unmapped read");
    c_swr: cover property (soft_reset_pulse);
    c_pin: cover property (pin_mode_source_enable && chip_mode == MSS_MODE3);
    c_unm: cover property (reg_rd && !hit);
endmodule : mss_props
bind mss_mode_select_soft_reset_reg mss_props #(.RAIL_OFF_CYCLES(RAIL_OFF_CYCLES)) u_props (
    .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pin_mode_source_enable(pin_mode_source_enable),
    .mode_select_pin(mode_select_pin), .chip_mode(chip_mode),
    .soft_reset_pulse(soft_reset_pulse), .rails_enable(rails_enable));
`default_nettype wire

// ### testbench.sv
/* self-checking bench for the control register top.
   short counts: 5 off cycles, 10 cycles a second. */
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import mss_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic pen = 1'b0;
    logic [1:0] pins = 2'h0;
    logic key = 1'b0;
    logic wr, rd, lp, srp, rails;
    logic [7:0] addr, wd, rdata, d;
    mss_mode_t mode;
    int bad_count = 0;
    int n_tests = 0;
    int n;
    int off_n = 0;
    localparam int RAIL_OFF = 5;
    localparam int SEC = 10;
    logic [9:0] rows [4] = '{{8'h18, 2'h3}, {8'h08, 2'h1}, {8'h10, 2'h2}, {8'hE3, 2'h0}};
    always #5 clk = ~clk;
    // regulator off time, counted away from the launching edge
    always @(negedge clk) begin
        if (rails === 1'b0) off_n++;
    end
    mss_host host (.clk(clk), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wd),
        .reg_rdata(rdata));
    mss_mode_select_soft_reset_reg #(.RAIL_OFF_CYCLES(RAIL_OFF), .SECOND_CYCLES(SEC)) dut (.clk(clk),
        .rst(rst), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wd), .reg_rdata(rdata),
        .pin_mode_source_enable(pen), .mode_select_pin(pins), .chip_mode(mode),
        .soft_reset_pulse(srp), .rails_enable(rails), .on_key_pressed(key), .long_press(lp));
    task automatic chk(input string nm, input logic [7:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic close_out();
        $display("checks %0d bad %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out
    initial begin
        repeat (5) @(posedge clk);
        #1;
        rst = 1'b0;
        host.acc(1'b0, 8'h0C, 8'h00, d);
        chk("reset", d, MSS_CTL3_RESET);
        foreach (rows[i]) begin
            host.acc(1'b1, 8'h0C, rows[i][9:2], d);
            chk("nopulse", {7'h0, srp}, 8'h00);
            host.acc(1'b0, 8'h0C, 8'h00, d);
            chk("rdback", d, rows[i][9:2]);
            chk("regmode", {6'h0, mode}, {6'h0, rows[i][1:0]});
            chk("rails", {7'h0, rails}, 8'h01);
        end
        pen = 1'b1;
        for (int p = 0; p < 4; p++) begin
            pins = p[1:0];
            repeat (2) @(posedge clk);
            #1;
            chk("pinmode", {6'h0, mode}, {6'h0, pins});
        end
        pen = 1'b0;
        host.acc(1'b1, 8'h0D, 8'hFF, d);
        host.acc(1'b0, 8'h0D, 8'h00, d);
        chk("unmapped", d, 8'h00);
        host.acc(1'b0, 8'h0C, 8'h00, d);
        chk("kept", d, 8'hE3);
        host.acc(1'b1, 8'h0C, 8'hFC, d);
        chk("railsoff", {7'h0, rails}, 8'h00);
        chk("pulse", {7'h0, srp}, 8'h01);
        host.acc(1'b0, 8'h0C, 8'h00, d);
        chk("swreset", d, MSS_CTL3_RESET);
        n = 0;
        while (rails !== 1'b1 && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("railson", {7'h0, rails}, 8'h01);
        chk("offtime", 8'(off_n), 8'(RAIL_OFF));
        // every timer code, pressed from the write onward
        for (int c = 0; c < 4; c++) begin
            host.acc(1'b1, 8'h0C, 8'(c), d);
            key = 1'b1;
            n = 0;
            while (lp !== 1'b1 && n < 200) begin
                @(posedge clk);
                #1;
                n++;
            end
            chk("press", n[7:0], 8'((c + 1) * MSS_TIMER_STEP_S * SEC));
            key = 1'b0;
        end
        close_out();
    end
endmodule : testbench
`default_nettype wire
